//--- rtl/pmcg_pkg.sv
// Package: register map, field layout and encodings of the clock control
package pmcg_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] MODE0_CLOCK_GATES_ADDR  = 12'h040;
	localparam logic [11:0] MODE0_CLOCK_SELECT_ADDR = 12'h044;
	localparam logic [11:0] MODE1_CLOCK_GATES_ADDR  = 12'h048;
	localparam logic [11:0] MODE1_CLOCK_SELECT_ADDR = 12'h04c;
	localparam logic [11:0] ACTIVE_GATES_VIEW_ADDR  = 12'h050;
	localparam logic [11:0] ACTIVE_SELECT_VIEW_ADDR = 12'h054;
	localparam logic [11:0] POWER_MODE_ADDR         = 12'h058;

	// ----------------------------------------------------------------
	// Reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [31:0] GATES_RESET  = 32'h00021807;
	localparam logic [31:0] SELECT_RESET = 32'h2a1a0a09;
	localparam logic [31:0] GATES_MASK   = 32'h00061dff;
	localparam logic [31:0] SELECT_MASK  = 32'hff3f1f1f;
	localparam logic [1:0]  MODE_MASK    = 2'h1;

	// ----------------------------------------------------------------
	// Gate bit positions
	// ----------------------------------------------------------------
	localparam int GATE_HOST     = 0;
	localparam int GATE_MEMCTL   = 1;
	localparam int GATE_DISPLAY  = 2;
	localparam int GATE_GRAPHICS = 3;
	localparam int GATE_CSC      = 4;
	localparam int GATE_VIDEO    = 5;
	localparam int GATE_GPIO     = 6;
	localparam int GATE_SERIAL_A = 7;
	localparam int GATE_SERIAL_B = 8;
	localparam int GATE_SYNCSER  = 10;
	localparam int GATE_USB_HOST = 11;
	localparam int GATE_USB_DEV  = 12;
	localparam int GATE_MICRO    = 17;
	localparam int GATE_AUDIO    = 18;
	localparam int GATE_COUNT    = 14;

	// ----------------------------------------------------------------
	// Clock select field layout
	// ----------------------------------------------------------------
	localparam int SEL_PANEL_SINGLE = 31;
	localparam int SEL_PANEL_SRC_HI = 30;
	localparam int SEL_PANEL_SRC_LO = 29;
	localparam int SEL_PANEL_DIV_HI = 28;
	localparam int SEL_PANEL_DIV_LO = 24;
	localparam int SEL_CRT_NODBL    = 21;
	localparam int SEL_CRT_SRC      = 20;
	localparam int SEL_CRT_DIV_LO   = 16;
	localparam int SEL_MAIN_SRC     = 12;
	localparam int SEL_MAIN_DIV_LO  = 8;
	localparam int SEL_LMEM_SRC     = 4;
	localparam int SEL_LMEM_DIV_LO  = 0;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] PANEL_SRC_288 = 2'h0;
	localparam logic [1:0] PANEL_SRC_336 = 2'h1;
	localparam logic [1:0] SRC_288       = 2'h0;
	localparam logic [1:0] SRC_336       = 2'h1;
	localparam logic [1:0] SRC_PLL       = 2'h2;
	localparam logic [1:0] MODE_FIRST    = 2'h0;
	localparam logic [1:0] MODE_SECOND   = 2'h1;

	// Decoded branch setting: source and full divisor
	typedef struct packed {
		logic [1:0]  src;
		logic [9:0]  divisor;
	} pmcg_branch_t;

	typedef struct packed {
		logic [31:0] gates0;
		logic [31:0] select0;
		logic [31:0] gates1;
		logic [31:0] select1;
		logic [1:0]  mode;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [GATE_COUNT-1:0] clkEn;
		logic        panelSingleRate;
		logic        crtNoDoubleFeed;
		pmcg_branch_t panel;
		pmcg_branch_t crt;
		pmcg_branch_t main;
		pmcg_branch_t lmem;
	} pmcg_state_t;

endpackage : pmcg_pkg

//--- rtl/pmcg_clock_control.sv
// Power mode clock gating and clock branch selection with an APB slave
//
// Contract
// RULE_01 - Bit 31 set: panel branch single rate
// RULE_02 - Panel source 00=288, 01=336, 1x=PLL
// RULE_03 - Panel divider: 2^n, 3*2^n, 5*2^n
// RULE_04 - Bit 21 set: CRT needs no double feed
// RULE_05 - CRT source bit: 0=288, 1=336
// RULE_06 - CRT divider: 2^n then 3*2^n
// RULE_07 - Main source bit: 0=288, 1=336
// RULE_08 - Main divider uses CRT divider encoding
// RULE_09 - Gate 18 enables audio clocks
// RULE_10 - Gate 17 enables microcontroller and SRAM
// RULE_11 - Gates 12/11 enable USB device/host
// RULE_12 - Gate 10 enables both synchronous serial
// RULE_13 - Gates 8/7 enable serial ports B/A
// RULE_14 - Gate 6 enables GPIO, PWM, two-wire
// RULE_15 - Gates 5/4 enable video input, CSC
// RULE_16 - Gates 3/2 enable graphics, display
// RULE_17 - Gates 1/0 enable memory, host/DMA
// RULE_18 - Gate registers reset to 0x00021807
// RULE_19 - Clock registers reset to 0x2A1A0A09
// RULE_20 - Local memory source/divider as main
// RULE_21 - Reserved bits read zero, ignore writes
// RULE_22 - Active mode's registers are applied
// RULE_23 - Current views mirror active mode
// RULE_24 - Software waits 16 ms between source changes
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps

module pmcg_clock_control #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ADDR_W-1:0]         paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Per-function clock enables
	output logic [pmcg_pkg::GATE_COUNT-1:0] clkEn,
	// Branch settings of the active mode
	output logic                           panelSingleRate,
	output logic                           crtNoDoubleFeed,
	output pmcg_pkg::pmcg_branch_t         panelBranch,
	output pmcg_pkg::pmcg_branch_t         crtBranch,
	output pmcg_pkg::pmcg_branch_t         mainBranch,
	output pmcg_pkg::pmcg_branch_t         lmemBranch,
	output logic [1:0]                     activeMode
);

	// ----------------------------------------------------------------
	// Decoders
	// ----------------------------------------------------------------
	// Four-bit divider: 2^n for n<8, 3*2^n above
	function automatic logic [9:0] div4(input logic [3:0] code);
		logic [9:0] base;
		base = code[3] ? 10'h003 : 10'h001;
		div4 = base << code[2:0];
	endfunction : div4

	// Five-bit panel divider adds a 5*2^n group; codes above it act as 1
	function automatic logic [9:0] div5(input logic [4:0] code);
		logic [9:0] base;
		unique case (code[4:3])
			2'h0:    base = 10'h001;
			2'h1:    base = 10'h003;
			2'h2:    base = 10'h005;
			default: base = 10'h001;
		endcase
		div5 = (code[4:3] == 2'h3) ? 10'h001 : (base << code[2:0]);
	endfunction : div5

	function automatic logic [1:0] srcBit(input logic b);
		srcBit = b ? pmcg_pkg::SRC_336 : pmcg_pkg::SRC_288;
	endfunction : srcBit

	// Byte-lane merge limited to writable bits
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] strb,
			input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = ((old & ~lanes) | (wd & lanes)) & mask;
	endfunction : merge

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pmcg_pkg::pmcg_state_t state_q;
	pmcg_pkg::pmcg_state_t state_d;

	logic [31:0] actGates;
	logic [31:0] actSelect;
	logic        access;
	logic        wrEn;
	logic [11:0] addr;

	always_comb begin
		addr   = 12'(paddr);
		access = psel & penable & ~state_q.pready;
		wrEn   = access & pwrite;
		// Active mode picks which pair drives the branches
		actGates  = (state_q.mode == pmcg_pkg::MODE_SECOND) ?
				state_q.gates1 : state_q.gates0; // RULE_22
		actSelect = (state_q.mode == pmcg_pkg::MODE_SECOND) ?
				state_q.select1 : state_q.select0; // RULE_22

		state_d         = state_q;
		state_d.pready  = access;
		state_d.pslverr = 1'b0;
		state_d.prdata  = 32'h00000000;

		if (access) begin
			unique case (addr)
				pmcg_pkg::MODE0_CLOCK_GATES_ADDR: begin
					state_d.prdata = state_q.gates0;
					if (wrEn)
						state_d.gates0 = merge(state_q.gates0, pwdata,
								pstrb, pmcg_pkg::GATES_MASK); // RULE_21
				end
				pmcg_pkg::MODE0_CLOCK_SELECT_ADDR: begin
					state_d.prdata = state_q.select0;
					if (wrEn)
						state_d.select0 = merge(state_q.select0, pwdata,
								pstrb, pmcg_pkg::SELECT_MASK); // RULE_21
				end
				pmcg_pkg::MODE1_CLOCK_GATES_ADDR: begin
					state_d.prdata = state_q.gates1;
					if (wrEn)
						state_d.gates1 = merge(state_q.gates1, pwdata,
								pstrb, pmcg_pkg::GATES_MASK); // RULE_21
				end
				pmcg_pkg::MODE1_CLOCK_SELECT_ADDR: begin
					state_d.prdata = state_q.select1;
					if (wrEn)
						state_d.select1 = merge(state_q.select1, pwdata,
								pstrb, pmcg_pkg::SELECT_MASK); // RULE_21
				end
				pmcg_pkg::ACTIVE_GATES_VIEW_ADDR: begin
					state_d.prdata  = actGates; // RULE_23
					state_d.pslverr = pwrite;
				end
				pmcg_pkg::ACTIVE_SELECT_VIEW_ADDR: begin
					state_d.prdata  = actSelect; // RULE_23
					state_d.pslverr = pwrite;
				end
				pmcg_pkg::POWER_MODE_ADDR: begin
					state_d.prdata = {30'h0, state_q.mode};
					// Only two modes exist here; sleep is handled elsewhere
					if (wrEn && pstrb[0])
						state_d.mode = pwdata[1:0] & pmcg_pkg::MODE_MASK;
				end
				default: state_d.pslverr = 1'b1;
			endcase
		end

		// Gate outputs, compacted in bit order
		state_d.clkEn = {
			actGates[pmcg_pkg::GATE_AUDIO],     // RULE_09
			actGates[pmcg_pkg::GATE_MICRO],     // RULE_10
			actGates[pmcg_pkg::GATE_USB_DEV],   // RULE_11
			actGates[pmcg_pkg::GATE_USB_HOST],  // RULE_11
			actGates[pmcg_pkg::GATE_SYNCSER],   // RULE_12
			actGates[pmcg_pkg::GATE_SERIAL_B],  // RULE_13
			actGates[pmcg_pkg::GATE_SERIAL_A],  // RULE_13
			actGates[pmcg_pkg::GATE_GPIO],      // RULE_14
			actGates[pmcg_pkg::GATE_VIDEO],     // RULE_15
			actGates[pmcg_pkg::GATE_CSC],       // RULE_15
			actGates[pmcg_pkg::GATE_GRAPHICS],  // RULE_16
			actGates[pmcg_pkg::GATE_DISPLAY],   // RULE_16
			actGates[pmcg_pkg::GATE_MEMCTL],    // RULE_17
			actGates[pmcg_pkg::GATE_HOST]       // RULE_17
		};

		state_d.panelSingleRate =
				actSelect[pmcg_pkg::SEL_PANEL_SINGLE]; // RULE_01
		state_d.panel.src = actSelect[pmcg_pkg::SEL_PANEL_SRC_HI] ?
				pmcg_pkg::SRC_PLL :
				srcBit(actSelect[pmcg_pkg::SEL_PANEL_SRC_LO]); // RULE_02
		state_d.panel.divisor = div5(actSelect[pmcg_pkg::SEL_PANEL_DIV_HI:
				pmcg_pkg::SEL_PANEL_DIV_LO]); // RULE_03
		state_d.crtNoDoubleFeed =
				actSelect[pmcg_pkg::SEL_CRT_NODBL]; // RULE_04
		state_d.crt.src = srcBit(actSelect[pmcg_pkg::SEL_CRT_SRC]); // RULE_05
		state_d.crt.divisor =
				div4(actSelect[pmcg_pkg::SEL_CRT_DIV_LO+:4]); // RULE_06
		state_d.main.src = srcBit(actSelect[pmcg_pkg::SEL_MAIN_SRC]); // RULE_07
		state_d.main.divisor =
				div4(actSelect[pmcg_pkg::SEL_MAIN_DIV_LO+:4]); // RULE_08
		state_d.lmem.src = srcBit(actSelect[pmcg_pkg::SEL_LMEM_SRC]); // RULE_20
		state_d.lmem.divisor =
				div4(actSelect[pmcg_pkg::SEL_LMEM_DIV_LO+:4]); // RULE_20
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Branch outputs lag register writes by one cycle; software must
	// still space source changes itself since nothing here enforces it
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q                 <= '0;
			state_q.gates0          <= pmcg_pkg::GATES_RESET;  // RULE_18
			state_q.gates1          <= pmcg_pkg::GATES_RESET;  // RULE_18
			state_q.select0         <= pmcg_pkg::SELECT_RESET; // RULE_19
			state_q.select1         <= pmcg_pkg::SELECT_RESET; // RULE_19
			state_q.mode            <= pmcg_pkg::MODE_FIRST;
			state_q.clkEn           <= 14'h1c07;
			state_q.panel.src       <= pmcg_pkg::PANEL_SRC_336;
			state_q.panel.divisor   <= 10'h00c;
			state_q.crtNoDoubleFeed <= 1'b0;
			state_q.crt.src         <= pmcg_pkg::SRC_336;
			state_q.crt.divisor     <= 10'h00c;
			state_q.main.src        <= pmcg_pkg::SRC_288;
			state_q.main.divisor    <= 10'h00c;
			state_q.lmem.src        <= pmcg_pkg::SRC_288;
			state_q.lmem.divisor    <= 10'h006;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata          = state_q.prdata;
	assign pready          = state_q.pready;
	assign pslverr         = state_q.pslverr;
	assign clkEn           = state_q.clkEn;
	assign panelSingleRate = state_q.panelSingleRate;
	assign crtNoDoubleFeed = state_q.crtNoDoubleFeed;
	assign panelBranch     = state_q.panel;
	assign crtBranch       = state_q.crt;
	assign mainBranch      = state_q.main;
	assign lmemBranch      = state_q.lmem;
	assign activeMode      = state_q.mode;

endmodule : pmcg_clock_control

//--- verif/pmcg_clock_control_chk.sv
// Checker: bus timing and branch outputs of the clock control block
`timescale 1ns/1ps

module pmcg_chk #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic                            ref_clk,
	input wire logic                            rst_n,
	// APB
	input wire logic                            psel,
	input wire logic                            penable,
	input wire logic                            pwrite,
	input wire logic [ADDR_W-1:0]               paddr,
	input wire logic [31:0]                     pwdata,
	input wire logic [3:0]                      pstrb,
	input wire logic                            pready,
	input wire logic                            pslverr,
	// Active mode outputs
	input wire logic [pmcg_pkg::GATE_COUNT-1:0] clkEn,
	input wire logic                            panelSingleRate,
	input wire logic                            crtNoDoubleFeed,
	input wire pmcg_pkg::pmcg_branch_t          panelBranch,
	input wire pmcg_pkg::pmcg_branch_t          crtBranch,
	input wire pmcg_pkg::pmcg_branch_t          mainBranch,
	input wire pmcg_pkg::pmcg_branch_t          lmemBranch,
	input wire logic [1:0]                      activeMode
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	logic [31:0] wdPrev;
	always_ff @(posedge ref_clk) begin
		wdPrev <= pwdata;
	end

	function automatic logic [13:0] gmap(input logic [31:0] w);
		return {w[18:17], w[12:10], w[8:0]};
	endfunction : gmap

	function automatic logic [9:0] div4(input logic [3:0] c);
		return c[3] ? (10'h003 << c[2:0]) : (10'h001 << c[2:0]);
	endfunction : div4

	// Full-word write of the active mode's registers, accepted
	sequence gateWr;
		pready && pwrite && !pslverr && pstrb == 4'hf &&
		((paddr == 12'h040 && activeMode == 2'h0) ||
		 (paddr == 12'h048 && activeMode == 2'h1));
	endsequence
	sequence selWr;
		pready && pwrite && !pslverr && pstrb == 4'hf &&
		((paddr == 12'h044 && activeMode == 2'h0) ||
		 (paddr == 12'h04c && activeMode == 2'h1));
	endsequence

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	pulse_once_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	answer_next_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered in the next cycle");
	no_stray_a: assert property (!(psel && penable) |=> !pready)
		else $error("pready without an access");
	gate_apply_a: assert property (gateWr |=> clkEn == gmap(wdPrev))
		else $error("clock enables do not follow gate write");
	rate_flags_a: assert property (selWr |=> panelSingleRate == wdPrev[31]
		&& crtNoDoubleFeed == wdPrev[21])
		else $error("rate flags do not follow select write");
	panel_src_a: assert property (selWr |=> panelBranch.src ==
		(wdPrev[30] ? 2'h2 : {1'b0, wdPrev[29]}))
		else $error("panel source wrong");
	branch_src_a: assert property (selWr |=> crtBranch.src ==
		{1'b0, wdPrev[20]} && mainBranch.src == {1'b0, wdPrev[12]}
		&& lmemBranch.src == {1'b0, wdPrev[4]})
		else $error("branch source wrong");
	divider_a: assert property (selWr |=> crtBranch.divisor ==
		div4(wdPrev[19:16]) && mainBranch.divisor == div4(wdPrev[11:8])
		&& lmemBranch.divisor == div4(wdPrev[3:0]))
		else $error("branch divisor wrong");
	view_err_a: assert property (pready && pwrite &&
		(paddr == 12'h050 || paddr == 12'h054) |-> pslverr)
		else $error("write to view not refused");
	reset_value_a: assert property ($rose(rst_n) |-> clkEn == 14'h1c07
		&& activeMode == 2'h0 && panelBranch.divisor == 10'h00c
		&& crtBranch.divisor == 10'h00c)
		else $error("outputs wrong after reset");
endmodule : pmcg_chk

bind pmcg_clock_control pmcg_chk #(.ADDR_W(ADDR_W)) i_pmcg_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .pslverr(pslverr), .clkEn(clkEn),
	.panelSingleRate(panelSingleRate), .crtNoDoubleFeed(crtNoDoubleFeed),
	.panelBranch(panelBranch), .crtBranch(crtBranch),
	.mainBranch(mainBranch), .lmemBranch(lmemBranch),
	.activeMode(activeMode));

//--- verif/power_mode_clock_gating_bench.sv
// Testbench: registers, gating and branch decoding of the clock control
`timescale 1ns/1ps

module power_mode_clock_gating_bench;
	logic                   ref_clk = 1'b0;
	logic                   rst_n   = 1'b0;
	logic                   psel    = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite  = 1'b0;
	logic [11:0]            paddr   = 12'h000;
	logic [31:0]            pwdata  = 32'h0;
	logic [3:0]             pstrb   = 4'hf;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic [13:0]            clkEn;
	logic                   panelSingleRate;
	logic                   crtNoDoubleFeed;
	pmcg_pkg::pmcg_branch_t panelBranch;
	pmcg_pkg::pmcg_branch_t crtBranch;
	pmcg_pkg::pmcg_branch_t mainBranch;
	pmcg_pkg::pmcg_branch_t lmemBranch;
	logic [1:0]             activeMode;
	int                     fails    = 0;
	int                     compares = 0;
	logic [31:0]            rd;
	logic                   er;
	logic [9:0]             pdiv;

	typedef struct {logic [11:0] a; logic [31:0] w;
		logic [31:0] r; logic [13:0] e;} pmcg_row_t;
	// Reserved bits must drop out of the readback
	pmcg_row_t rows [6] = '{
		'{12'h040, 32'hffffffff, 32'h00061dff, 14'h3fff},
		'{12'h044, 32'hffffffff, 32'hff3f1f1f, 14'h3fff},
		'{12'h048, 32'h00000000, 32'h00000000, 14'h3fff},
		'{12'h04c, 32'h2a1a0a09, 32'h2a1a0a09, 14'h3fff},
		'{12'h040, 32'h00000155, 32'h00000155, 14'h0155},
		'{12'h040, 32'h00060000, 32'h00060000, 14'h3000}};

	always #12.5 ref_clk = ~ref_clk;

	pmcg_clock_control #(.ADDR_W(12)) i_pmcg_clock_control (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .clkEn(clkEn),
		.panelSingleRate(panelSingleRate), .crtNoDoubleFeed(crtNoDoubleFeed),
		.panelBranch(panelBranch), .crtBranch(crtBranch),
		.mainBranch(mainBranch), .lmemBranch(lmemBranch),
		.activeMode(activeMode));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task test_done;
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Bounded wait: a dead slave ends the run instead of hanging it
	task apb(input logic [11:0] a, input logic wr, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
		if (n >= 20) begin
			fails++;
			test_done;
		end
	endtask : apb

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		int c;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].a, 1'b1, rows[i].w, rd, er);
			apb(rows[i].a, 1'b0, 32'h0, rd, er);
			chk(rd, rows[i].r);
			chk({18'h0, clkEn}, {18'h0, rows[i].e});
		end
		// Sources change back to back: the block must not rely on spacing
		for (c = 0; c < 24; c++) begin
			apb(12'h044, 1'b1, {c[2], c[1:0], c[4:0], 2'b00, c[1], c[0],
				c[3:0], 3'b000, c[1], c[3:0], 3'b000, c[2], c[3:0]}, rd, er);
			pdiv = c < 8 ? 10'h1 << c : (c < 16 ? 10'h3 << (c - 8)
				: 10'h5 << (c - 16));
			chk({22'h0, panelBranch.divisor}, {22'h0, pdiv});
			chk({30'h0, panelBranch.src}, c[1] ? 32'h2 : {31'h0, c[0]});
			chk({31'h0, panelSingleRate}, {31'h0, c[2]});
			chk({31'h0, crtNoDoubleFeed}, {31'h0, c[1]});
			pdiv = (c[3] ? 10'h3 : 10'h1) << c[2:0];
			chk({22'h0, crtBranch.divisor}, {22'h0, pdiv});
			chk({30'h0, mainBranch.src}, {31'h0, c[1]});
			chk({30'h0, lmemBranch.src}, {31'h0, c[2]});
		end
		apb(12'h048, 1'b1, 32'h00040001, rd, er);
		apb(12'h058, 1'b1, 32'h00000001, rd, er);
		chk({18'h0, clkEn}, 32'h00002001);
		chk({30'h0, crtBranch.src}, 32'h1);
		apb(12'h050, 1'b0, 32'h0, rd, er);
		chk(rd, 32'h00040001);
		apb(12'h054, 1'b0, 32'h0, rd, er);
		chk(rd, 32'h2a1a0a09);
		apb(12'h054, 1'b1, 32'hffffffff, rd, er);
		chk({31'h0, er}, 32'h1);
		apb(12'h100, 1'b0, 32'h0, rd, er);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		// Low byte lane only: upper lanes keep their old bits
		@(posedge ref_clk);
		pstrb <= 4'h1;
		apb(12'h048, 1'b1, 32'hffffffff, rd, er);
		apb(12'h048, 1'b0, 32'h0, rd, er);
		chk(rd, 32'h000400ff);
		chk({18'h0, clkEn}, 32'h000020ff);
		@(posedge ref_clk);
		pstrb <= 4'hf;
		// Second reset in mid-run
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		chk({18'h0, clkEn}, 32'h00001c07);
		chk({22'h0, crtBranch.divisor}, 32'h0000000c);
		chk({30'h0, activeMode}, 32'h0);
		apb(12'h048, 1'b0, 32'h0, rd, er);
		chk(rd, 32'h00021807);
		apb(12'h04c, 1'b0, 32'h0, rd, er);
		chk(rd, 32'h2a1a0a09);
		test_done;
	end
endmodule : power_mode_clock_gating_bench
